// file: bench/dpbc_far_model.sv
`timescale 1ns/1ps
module dpbc_far_model #(
   parameter int LAG = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic spindleOn,
   output logic spindleAtSpeed,
   input wire logic accessStart,
   output logic accessDone
);
   int spin_r;
   int dly_r;
   // ------------------------------------------------
   // Spindle and media
   // ------------------------------------------------
   // Speed ramps with the motor drive; the media ends a fixed time after start.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         spin_r <= 0;
         dly_r <= 0;
      end else begin
         spin_r <= spindleOn ? (spin_r < LAG ? spin_r + 1 : LAG) : (spin_r > 0 ? spin_r - 1 : 0);
         dly_r <= accessStart ? LAG : (dly_r > 0 ? dly_r - 1 : 0);
      end
   end
   // Full speed only at the top of the ramp, so a stopping motor reads as stopped.
   assign spindleAtSpeed = spin_r == LAG;
   assign accessDone = dly_r == 1;
endmodule

// file: bench/dpbc_top_monitor.sv
`timescale 1ns/1ps
module dpbc_top_monitor
   import dpbc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cmdValid,
   input wire logic cmdReady,
   input wire logic [7:0] cmdCode,
   input wire logic [7:0] sectorCountRegRet,
   input wire logic sectorCountRegWe,
   input wire logic accessReq,
   input wire logic accessStart,
   input wire logic spindleOn,
   input wire logic busy,
   input wire logic dataReq,
   input wire logic ready,
   input wire logic intrq
);
   logic tk;
   logic isChk;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ------------------------------------------------
   // Command port checks
   // ------------------------------------------------
   // A command is taken when offer and acceptance meet.
   assign tk = cmdValid && cmdReady;
   assign isChk = cmdCode == CMD_CHECK_A || cmdCode == CMD_CHECK_B;
   chk_check_idle: assert property (tk && isChk && spindleOn
      |=> sectorCountRegWe && sectorCountRegRet == SC_RET_IDLE) else $error("check power in idle wrong");
   chk_check_stby: assert property (tk && isChk && !spindleOn
      |=> sectorCountRegWe && sectorCountRegRet == SC_RET_STBY) else $error("check power in standby wrong");
   chk_stby_irq: assert property (tk && (cmdCode == CMD_STBY_IMM_A || cmdCode == CMD_STBY_IMM_B) && spindleOn
      |=> intrq && !spindleOn) else $error("standby immediate interrupt late");
   chk_rd_seq: assert property (tk && cmdCode == CMD_RD_BUF
      |=> busy ##1 (!busy && dataReq && intrq)) else $error("read buffer sequence wrong");
   chk_wr_seq: assert property (tk && cmdCode == CMD_WR_BUF
      |=> busy ##1 (!busy && dataReq && !intrq)) else $error("write buffer sequence wrong");
   chk_access_go: assert property (accessReq && cmdReady && !cmdValid && spindleOn
      |=> accessStart && busy) else $error("access not started");
   chk_sleep_mute: assert property (!ready |-> !cmdReady) else $error("command accepted asleep");
   chk_ready_cmd: assert property (cmdReady |-> ready) else $error("ready low while accepting");
   cover property (tk && isChk);
   cover property (intrq && !ready);
   cover property (accessStart);
endmodule
bind dpbc_top dpbc_top_monitor dpbc_top_monitor_i (.clk, .rst, .cmdValid, .cmdReady, .cmdCode,
   .sectorCountRegRet, .sectorCountRegWe, .accessReq, .accessStart, .spindleOn, .busy, .dataReq, .ready, .intrq);

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import dpbc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmdValid = 1'b0;
   logic [7:0] cmdCode = 8'h00;
   logic [7:0] sectorCountReg = 8'h00;
   logic accessReq = 1'b0;
   logic hostResetPin = 1'b0;
   logic [15:0] hostWrData = 16'h0000;
   logic hostWrValid = 1'b0;
   logic hostRdReady = 1'b0;
   logic cmdReady, sectorCountRegWe, accessStart, accessDone, spindleOn, spindleAtSpeed;
   logic busy, dataReq, ready, intrq, hostWrReady, hostRdValid;
   logic [7:0] sectorCountRegRet;
   logic [15:0] hostRdData;
   int nErrors = 0;
   int nTests = 0;
   dpbc_top #(.TICK_CYCLES(4)) dpbc_top_i (.clk, .rst, .cmdValid, .cmdReady, .cmdCode, .sectorCountReg,
      .sectorCountRegRet, .sectorCountRegWe, .accessReq, .accessStart, .accessDone, .spindleOn,
      .spindleAtSpeed, .hostResetPin, .busy, .dataReq, .ready, .intrq, .hostWrData, .hostWrValid,
      .hostWrReady, .hostRdData, .hostRdValid, .hostRdReady);
   dpbc_far_model dpbc_far_model_i (.clk, .rst, .spindleOn, .spindleAtSpeed, .accessStart, .accessDone);
   // ------------------------------------------------
   // Host tasks
   // ------------------------------------------------
   // Clock of 4 ns.
   always #2 clk = ~clk;
   function automatic logic [15:0] pat(input int k);
      return 16'(k) ^ 16'hc3c3;
   endfunction
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      nTests++;
      if (got !== exp) begin
         nErrors++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", nTests, nErrors);
      if (nErrors == 0 && nTests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] s);
      cmdValid <= 1'b1;
      cmdCode <= c;
      sectorCountReg <= s;
      @(posedge clk);
      while (cmdReady !== 1'b1) @(posedge clk);
      cmdValid <= 1'b0;
   endtask
   task automatic irq(input logic spd);
      for (int i = 0; i < 300 && intrq !== 1'b1; i++) @(posedge clk);
      chk("intrq", 16'(intrq), 16'h0001);
      chk("atSpeed", 16'(spindleAtSpeed), 16'(spd));
   endtask
   task automatic sret(input logic [7:0] e);
      @(posedge clk);
      chk("scWe", 16'(sectorCountRegWe), 16'h0001);
      chk("scRet", 16'(sectorCountRegRet), 16'(e));
   endtask
   // Pops one sector while the host stalls every other cycle.
   task automatic rd(input logic ident);
      int k;
      k = 0;
      while (k < 256) begin
         @(posedge clk);
         if (hostRdValid === 1'b1 && hostRdReady === 1'b1) begin
            chk("rdWord", hostRdData, ident ? (k == 0 ? IDENT_CFG_WORD : 16'h0000) : pat(k));
            k++;
         end
         hostRdReady <= (k < 256) && !hostRdReady;
      end
   endtask
   // Watchdog for a hung handshake.
   initial begin
      repeat (20000) @(posedge clk);
      nErrors++;
      final_report();
   end
   // Main sequence.
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      cmd(CMD_CHECK_A, 8'h00);
      sret(SC_RET_IDLE);
      cmd(CMD_STBY_IMM_B, 8'h07);
      irq(1'b1);
      cmd(CMD_CHECK_B, 8'h00);
      sret(SC_RET_STBY);
      cmd(CMD_IDLE_IMM_A, 8'h00);
      irq(1'b1);
      cmd(CMD_IDLE_B, 8'h01);
      irq(1'b1);
      repeat (12) @(posedge clk);
      chk("spinHold", 16'(spindleOn), 16'h0001);
      repeat (20) @(posedge clk);
      chk("spinOff", 16'(spindleOn), 16'h0000);
      accessReq <= 1'b1;
      @(posedge clk);
      while (accessStart !== 1'b1) @(posedge clk);
      accessReq <= 1'b0;
      chk("spunUp", 16'(spindleAtSpeed), 16'h0001);
      while (busy !== 1'b0) @(posedge clk);
      accessReq <= 1'b1;
      repeat (2) @(posedge clk);
      accessReq <= 1'b0;
      chk("acc", 16'(accessStart), 16'h0001);
      while (busy !== 1'b0) @(posedge clk);
      repeat (12) @(posedge clk);
      cmd(CMD_CHECK_A, 8'h00);
      sret(SC_RET_IDLE);
      cmd(CMD_IDLE_A, 8'hff);
      irq(1'b1);
      $display("test power modes done");
      cmd(CMD_WR_BUF, 8'h00);
      for (int k = 0; k < 256; k++) begin
         hostWrValid <= 1'b1;
         hostWrData <= pat(k);
         @(posedge clk);
         while (hostWrReady !== 1'b1) @(posedge clk);
      end
      hostWrValid <= 1'b0;
      irq(1'b1);
      cmd(CMD_RD_BUF, 8'h00);
      irq(1'b1);
      chk("dataReq", 16'(dataReq), 16'h0001);
      rd(1'b0);
      cmd(CMD_IDENTIFY, 8'h00);
      irq(1'b1);
      rd(1'b1);
      $display("test buffers done");
      cmd(CMD_STBY_A, 8'h02);
      irq(1'b0);
      cmd(CMD_STBY_IMM_A, 8'h00);
      irq(1'b0);
      cmd(CMD_SLEEP_B, 8'h33);
      irq(1'b0);
      repeat (4) @(posedge clk);
      chk("ready", 16'(ready), 16'h0000);
      chk("cmdReady", 16'(cmdReady), 16'h0000);
      hostResetPin <= 1'b1;
      cmd(CMD_CHECK_A, 8'h00);
      hostResetPin <= 1'b0;
      sret(SC_RET_STBY);
      $display("test sleep done");
      final_report();
   end
endmodule

// file: src/dpbc_fifo.sv
`timescale 1ns/1ps
module dpbc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] slot;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } dpbc_fifo_regs_t;

   dpbc_fifo_regs_t s_r;
   dpbc_fifo_regs_t s_nxt;
   logic push;
   logic pop;

   // Full and empty come straight from the fill count.
   assign inReady = (s_r.cnt != (AW + 1)'(DEPTH));
   assign outValid = (s_r.cnt != '0);
   assign outData = s_r.slot[s_r.rp];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // Pointer and count update for one push and one pop per cycle.
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.slot[s_r.wp] = inData;
         s_nxt.wp = AW'(s_r.wp + 1'b1);
      end
      if (pop) begin
         s_nxt.rp = AW'(s_r.rp + 1'b1);
      end
      if (push && !pop) begin
         s_nxt.cnt = (AW + 1)'(s_r.cnt + 1'b1);
      end else if (pop && !push) begin
         s_nxt.cnt = (AW + 1)'(s_r.cnt - 1'b1);
      end
   end

   // State register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule

// file: src/dpbc_mem_if.sv
`timescale 1ns/1ps
interface dpbc_mem_if;
   import dpbc_pkg::*;

   // ----------------------------------------------------------------
   // Sector buffer port
   // ----------------------------------------------------------------
   logic we;
   logic [BUF_AW-1:0] addr;
   logic [WORD_W-1:0] wdata;
   logic [WORD_W-1:0] rdata;

   modport ctl (output we, output addr, output wdata, input rdata);
   modport mem (input we, input addr, input wdata, output rdata);
endinterface

// file: src/dpbc_pkg.sv
package dpbc_pkg;

   // ----------------------------------------------------------------
   // Clock and timer constants
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 250_000_000;
   localparam int TIMER_TICK_S = 1;
   localparam int TICK_CYCLES_DEF = CLK_HZ * TIMER_TICK_S;
   localparam int TICK_W = 28;
   localparam int SEC_W = 12;
   localparam int AUTO_DEF_MIN = 45;
   localparam logic [SEC_W-1:0] AUTO_DEF_SEC = SEC_W'(AUTO_DEF_MIN * 60);
   localparam logic [SEC_W-1:0] SC_STEP_SEC = 12'h005;

   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_STBY_IMM_A = 8'he0;
   localparam logic [7:0] CMD_STBY_IMM_B = 8'h94;
   localparam logic [7:0] CMD_IDLE_IMM_A = 8'he1;
   localparam logic [7:0] CMD_IDLE_IMM_B = 8'h95;
   localparam logic [7:0] CMD_STBY_A = 8'he2;
   localparam logic [7:0] CMD_STBY_B = 8'h96;
   localparam logic [7:0] CMD_IDLE_A = 8'he3;
   localparam logic [7:0] CMD_IDLE_B = 8'h97;
   localparam logic [7:0] CMD_CHECK_A = 8'he5;
   localparam logic [7:0] CMD_CHECK_B = 8'h98;
   localparam logic [7:0] CMD_SLEEP_A = 8'he6;
   localparam logic [7:0] CMD_SLEEP_B = 8'h99;
   localparam logic [7:0] CMD_RD_BUF = 8'he4;
   localparam logic [7:0] CMD_WR_BUF = 8'he8;
   localparam logic [7:0] CMD_IDENTIFY = 8'hec;

   // ----------------------------------------------------------------
   // Sector count return values
   // ----------------------------------------------------------------
   localparam logic [7:0] SC_RET_IDLE = 8'hff;
   localparam logic [7:0] SC_RET_STBY = 8'h00;
   localparam logic [7:0] SC_RET_DONE = 8'h00;

   // ----------------------------------------------------------------
   // Sector buffer and data path
   // ----------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int BUF_AW = 8;
   localparam int XFER_W = 9;
   localparam logic [XFER_W-1:0] SECTOR_WORDS = 9'h100;
   localparam logic [XFER_W-1:0] SECTOR_LAST = 9'h0ff;
   localparam int FIFO_DEPTH = 8;
   // Value is arbitrary; the real parameter table is outside this block.
   localparam logic [WORD_W-1:0] IDENT_CFG_WORD = 16'h5a01;

   // ----------------------------------------------------------------
   // Controller states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_STANDBY = 4'h1,
      ST_SPINDOWN = 4'h2,
      ST_SPINUP = 4'h3,
      ST_SLEEPDN = 4'h4,
      ST_SLEEP = 4'h5,
      ST_ACCESS = 4'h6,
      ST_BUFSET = 4'h7,
      ST_BUFPREP = 4'h8,
      ST_BUFOUT = 4'h9,
      ST_BUFIN = 4'ha
   } dpbc_state_t;

endpackage

// file: src/dpbc_sector_mem.sv
`timescale 1ns/1ps
module dpbc_sector_mem
   import dpbc_pkg::*;
(
   input wire logic clk,
   dpbc_mem_if.mem bus
);

   logic [WORD_W-1:0] store [0:(1 << BUF_AW)-1];

   // One sector of words; read data comes out of a register one cycle later.
   always_ff @(posedge clk) begin
      if (bus.we) begin
         store[bus.addr] <= bus.wdata;
      end
      bus.rdata <= store[bus.addr];
   end

endmodule

// file: src/dpbc_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Stand-by immediate enters stand-by, ignores count.
// - Already in stand-by: no-op, timer stays off.
// - Stand-by immediate interrupts before spindle stops.
// - Idle immediate enters idle, starts enabled timer.
// - Idle immediate interrupts once idle is reached.
// - Stand-by, nonzero count: stand-by plus auto timer.
// - Stand-by, zero count: stand-by then idle.
// - Count zero is 45 minutes, else count times five.
// - Timer expiry in idle enters stand-by.
// - Access in stand-by spins up, then executes.
// - Access completion reloads the stand-by timer.
// - Idle command enters idle, enables auto timer.
// - Power-on: auto stand-by on, 45 minutes.
// - Check power returns 00h stand-by, FFh idle.
// - Sleep enters sleep, interrupts once there.
// - Host reset wakes sleep into stand-by.
// - Read buffer: busy, prepare, request, release, interrupt.
// - Write buffer: prepare, request, host writes sector.
// - Identify: busy, fill buffer, request, interrupt.
// - Access completion returns device to idle.
// - Idle or stand-by: ready set, commands accepted.
module dpbc_top
   import dpbc_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic [7:0] cmdCode,
   input wire logic [7:0] sectorCountReg,
   output logic [7:0] sectorCountRegRet,
   output logic sectorCountRegWe,
   input wire logic accessReq,
   output logic accessStart,
   input wire logic accessDone,
   output logic spindleOn,
   input wire logic spindleAtSpeed,
   input wire logic hostResetPin,
   output logic busy,
   output logic dataReq,
   output logic ready,
   output logic intrq,
   input wire logic [WORD_W-1:0] hostWrData,
   input wire logic hostWrValid,
   output logic hostWrReady,
   output logic [WORD_W-1:0] hostRdData,
   output logic hostRdValid,
   input wire logic hostRdReady
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      dpbc_state_t st;
      logic busy;
      logic drq;
      logic intrq;
      logic scWe;
      logic [7:0] scRet;
      logic autoEn;
      logic timerRun;
      logic [SEC_W-1:0] periodSec;
      logic [SEC_W-1:0] secLeft;
      logic [TICK_W-1:0] tickCnt;
      logic intrPend;
      logic idleAfter;
      logic accessPend;
      logic retStandby;
      logic bufWrite;
      logic accessStart;
      logic spindleOn;
      logic pend;
      logic [XFER_W-1:0] addr;
      logic [XFER_W-1:0] xferCnt;
      logic [1:0] spdSync;
      logic [1:0] rstSync;
   } dpbc_regs_t;

   // Power-on spins up into idle with the default auto stand-by period.
   localparam dpbc_regs_t REGS_RST = '{st: ST_SPINUP, busy: 1'b1, drq: 1'b0, intrq: 1'b0, scWe: 1'b0,
      scRet: 8'h00, autoEn: 1'b1, timerRun: 1'b1, periodSec: AUTO_DEF_SEC, secLeft: AUTO_DEF_SEC,
      tickCnt: '0, intrPend: 1'b0, idleAfter: 1'b0, accessPend: 1'b0, retStandby: 1'b0, bufWrite: 1'b0,
      accessStart: 1'b0, spindleOn: 1'b1, pend: 1'b0, addr: '0, xferCnt: '0, spdSync: 2'b00,
      rstSync: 2'b00};
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   dpbc_regs_t s_r;
   dpbc_regs_t s_nxt;
   dpbc_mem_if memBus ();
   logic atSpeed;
   logic hostRst;
   logic tick;
   logic take;
   logic takeAcc;
   logic fifoInValid;
   logic fifoInReady;
   logic [WORD_W-1:0] fifoInData;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [WORD_W-1:0] fifoOutData;
   logic hostPop;

   // Converts a sector count into the auto stand-by period in seconds.
   function automatic logic [SEC_W-1:0] periodFromSc(input logic [7:0] sc);
      if (sc == 8'h00) begin
         return AUTO_DEF_SEC;
      end
      return SEC_W'(SEC_W'(sc) * SC_STEP_SEC);
   endfunction

   // ----------------------------------------------------------------
   // Data path: sector buffer and FIFO
   // ----------------------------------------------------------------
   dpbc_sector_mem u_mem (
      .clk (clk),
      .bus (memBus)
   );

   dpbc_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk (clk),
      .rst (rst),
      .inValid (fifoInValid),
      .inReady (fifoInReady),
      .inData (fifoInData),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData (fifoOutData)
   );

   // The FIFO is filled by the host on writes and by the buffer on reads.
   assign fifoInValid = (s_r.st == ST_BUFIN) ? hostWrValid : s_r.pend;
   assign fifoInData = (s_r.st == ST_BUFIN) ? hostWrData : memBus.rdata;
   assign fifoOutReady = (s_r.st == ST_BUFOUT) ? hostRdReady : (s_r.st == ST_BUFIN);
   assign hostWrReady = (s_r.st == ST_BUFIN) && fifoInReady;
   assign hostRdValid = (s_r.st == ST_BUFOUT) && fifoOutValid;
   assign hostRdData = fifoOutData;
   assign hostPop = hostRdValid && hostRdReady;
   assign memBus.addr = s_r.addr[BUF_AW-1:0];

   // ----------------------------------------------------------------
   // Control
   // ----------------------------------------------------------------
   // Commands are taken only while idle or in stand-by; sleep takes none.
   assign cmdReady = (s_r.st == ST_IDLE) || (s_r.st == ST_STANDBY);
   assign take = cmdValid && cmdReady;
   assign takeAcc = accessReq && cmdReady && !cmdValid;
   assign atSpeed = s_r.spdSync[1];
   assign hostRst = s_r.rstSync[1];
   assign tick = (s_r.tickCnt == TICK_LAST);

   // Next-state logic for power modes, commands and buffer transfers.
   always_comb begin
      s_nxt = s_r;
      s_nxt.intrq = 1'b0;
      s_nxt.scWe = 1'b0;
      s_nxt.accessStart = 1'b0;
      s_nxt.pend = 1'b0;
      s_nxt.spdSync = {s_r.spdSync[0], spindleAtSpeed};
      s_nxt.rstSync = {s_r.rstSync[0], hostResetPin};
      s_nxt.tickCnt = tick ? '0 : TICK_W'(s_r.tickCnt + 1'b1);
      memBus.we = 1'b0;
      memBus.wdata = '0;
      if (tick && s_r.st == ST_IDLE && s_r.timerRun && s_r.secLeft != '0) begin
         s_nxt.secLeft = SEC_W'(s_r.secLeft - 1'b1);
      end
      case (s_r.st)
         ST_IDLE, ST_STANDBY: begin
            if (take) begin
               s_nxt.secLeft = s_r.periodSec;
               s_nxt.tickCnt = '0;
               s_nxt.retStandby = (s_r.st == ST_STANDBY);
               case (cmdCode)
                  CMD_STBY_IMM_A, CMD_STBY_IMM_B: begin
                     s_nxt.timerRun = 1'b0;
                     s_nxt.intrq = 1'b1;
                     if (s_r.st == ST_IDLE) begin
                        s_nxt.st = ST_SPINDOWN;
                        s_nxt.spindleOn = 1'b0;
                        s_nxt.idleAfter = 1'b0;
                        s_nxt.intrPend = 1'b0;
                     end
                  end
                  CMD_IDLE_IMM_A, CMD_IDLE_IMM_B: begin
                     s_nxt.timerRun = s_r.autoEn;
                     if (s_r.st == ST_IDLE) begin
                        s_nxt.intrq = 1'b1;
                     end else begin
                        s_nxt.st = ST_SPINUP;
                        s_nxt.spindleOn = 1'b1;
                        s_nxt.busy = 1'b1;
                        s_nxt.intrPend = 1'b1;
                     end
                  end
                  CMD_STBY_A, CMD_STBY_B: begin
                     s_nxt.autoEn = 1'b1;
                     s_nxt.timerRun = 1'b1;
                     s_nxt.periodSec = periodFromSc(sectorCountReg);
                     s_nxt.secLeft = periodFromSc(sectorCountReg);
                     s_nxt.busy = 1'b1;
                     s_nxt.intrPend = 1'b1;
                     if (s_r.st == ST_IDLE) begin
                        s_nxt.st = ST_SPINDOWN;
                        s_nxt.spindleOn = 1'b0;
                        s_nxt.idleAfter = (sectorCountReg == 8'h00);
                     end else if (sectorCountReg == 8'h00) begin
                        s_nxt.st = ST_SPINUP;
                        s_nxt.spindleOn = 1'b1;
                     end else begin
                        s_nxt.busy = 1'b0;
                        s_nxt.intrPend = 1'b0;
                        s_nxt.intrq = 1'b1;
                     end
                  end
                  CMD_IDLE_A, CMD_IDLE_B: begin
                     s_nxt.autoEn = 1'b1;
                     s_nxt.timerRun = 1'b1;
                     s_nxt.periodSec = periodFromSc(sectorCountReg);
                     s_nxt.secLeft = periodFromSc(sectorCountReg);
                     if (s_r.st == ST_IDLE) begin
                        s_nxt.intrq = 1'b1;
                     end else begin
                        s_nxt.st = ST_SPINUP;
                        s_nxt.spindleOn = 1'b1;
                        s_nxt.busy = 1'b1;
                        s_nxt.intrPend = 1'b1;
                     end
                  end
                  CMD_CHECK_A, CMD_CHECK_B: begin
                     s_nxt.scRet = (s_r.st == ST_IDLE) ? SC_RET_IDLE : SC_RET_STBY;
                     s_nxt.scWe = 1'b1;
                     s_nxt.intrq = 1'b1;
                  end
                  CMD_SLEEP_A, CMD_SLEEP_B: begin
                     s_nxt.st = ST_SLEEPDN;
                     s_nxt.spindleOn = 1'b0;
                     s_nxt.busy = 1'b1;
                     s_nxt.timerRun = 1'b0;
                  end
                  CMD_RD_BUF, CMD_WR_BUF: begin
                     s_nxt.st = ST_BUFSET;
                     s_nxt.busy = 1'b1;
                     s_nxt.bufWrite = (cmdCode == CMD_WR_BUF);
                  end
                  CMD_IDENTIFY: begin
                     s_nxt.st = ST_BUFPREP;
                     s_nxt.busy = 1'b1;
                     s_nxt.bufWrite = 1'b0;
                     s_nxt.addr = '0;
                  end
                  default: begin
                  end
               endcase
            end else if (takeAcc) begin
               s_nxt.busy = 1'b1;
               s_nxt.secLeft = s_r.periodSec;
               s_nxt.tickCnt = '0;
               if (s_r.st == ST_STANDBY) begin
                  s_nxt.st = ST_SPINUP;
                  s_nxt.spindleOn = 1'b1;
                  s_nxt.accessPend = 1'b1;
               end else begin
                  s_nxt.st = ST_ACCESS;
                  s_nxt.accessStart = 1'b1;
               end
            end else if (s_r.st == ST_IDLE && s_r.timerRun && s_r.secLeft == '0) begin
               s_nxt.st = ST_SPINDOWN;
               s_nxt.spindleOn = 1'b0;
               s_nxt.timerRun = 1'b0;
               s_nxt.idleAfter = 1'b0;
            end
         end
         ST_SPINDOWN: begin
            if (!atSpeed) begin
               if (s_r.idleAfter) begin
                  s_nxt.st = ST_SPINUP;
                  s_nxt.spindleOn = 1'b1;
                  s_nxt.idleAfter = 1'b0;
               end else begin
                  s_nxt.st = ST_STANDBY;
                  s_nxt.busy = 1'b0;
                  s_nxt.intrq = s_r.intrPend;
                  s_nxt.intrPend = 1'b0;
               end
            end
         end
         ST_SPINUP: begin
            if (atSpeed) begin
               s_nxt.secLeft = s_r.periodSec;
               s_nxt.tickCnt = '0;
               if (s_r.accessPend) begin
                  s_nxt.st = ST_ACCESS;
                  s_nxt.accessStart = 1'b1;
                  s_nxt.accessPend = 1'b0;
               end else begin
                  s_nxt.st = ST_IDLE;
                  s_nxt.busy = 1'b0;
                  s_nxt.intrq = s_r.intrPend;
                  s_nxt.intrPend = 1'b0;
               end
            end
         end
         ST_ACCESS: begin
            if (accessDone) begin
               s_nxt.st = ST_IDLE;
               s_nxt.busy = 1'b0;
               s_nxt.secLeft = s_r.periodSec;
               s_nxt.tickCnt = '0;
               s_nxt.timerRun = s_r.autoEn;
            end
         end
         ST_SLEEPDN: begin
            if (!atSpeed) begin
               s_nxt.st = ST_SLEEP;
               s_nxt.busy = 1'b0;
               s_nxt.intrq = 1'b1;
            end
         end
         ST_SLEEP: begin
            if (hostRst) begin
               s_nxt.st = ST_STANDBY;
            end
         end
         ST_BUFPREP: begin
            memBus.we = 1'b1;
            memBus.wdata = (s_r.addr == '0) ? IDENT_CFG_WORD : '0;
            s_nxt.addr = XFER_W'(s_r.addr + 1'b1);
            if (s_r.addr == SECTOR_LAST) begin
               s_nxt.st = ST_BUFSET;
            end
         end
         ST_BUFSET: begin
            s_nxt.busy = 1'b0;
            s_nxt.drq = 1'b1;
            s_nxt.addr = '0;
            s_nxt.xferCnt = '0;
            if (s_r.bufWrite) begin
               s_nxt.st = ST_BUFIN;
            end else begin
               s_nxt.st = ST_BUFOUT;
               s_nxt.intrq = 1'b1;
            end
         end
         ST_BUFOUT: begin
            // One buffer read in flight at a time keeps the FIFO from overrunning.
            if (s_r.addr != SECTOR_WORDS && fifoInReady && !s_r.pend) begin
               s_nxt.pend = 1'b1;
               s_nxt.addr = XFER_W'(s_r.addr + 1'b1);
            end
            if (hostPop) begin
               s_nxt.xferCnt = XFER_W'(s_r.xferCnt + 1'b1);
               if (s_r.xferCnt == SECTOR_LAST) begin
                  s_nxt.drq = 1'b0;
                  s_nxt.scRet = SC_RET_DONE;
                  s_nxt.scWe = 1'b1;
                  s_nxt.st = s_r.retStandby ? ST_STANDBY : ST_IDLE;
               end
            end
         end
         ST_BUFIN: begin
            if (fifoOutValid) begin
               memBus.we = 1'b1;
               memBus.wdata = fifoOutData;
               s_nxt.addr = XFER_W'(s_r.addr + 1'b1);
               if (s_r.addr == SECTOR_LAST) begin
                  s_nxt.drq = 1'b0;
                  s_nxt.scRet = SC_RET_DONE;
                  s_nxt.scWe = 1'b1;
                  s_nxt.intrq = 1'b1;
                  s_nxt.st = s_r.retStandby ? ST_STANDBY : ST_IDLE;
               end
            end
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= REGS_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign busy = s_r.busy;
   assign dataReq = s_r.drq;
   assign ready = (s_r.st != ST_SLEEP) && (s_r.st != ST_SLEEPDN);
   assign intrq = s_r.intrq;
   assign sectorCountRegRet = s_r.scRet;
   assign sectorCountRegWe = s_r.scWe;
   assign accessStart = s_r.accessStart;
   assign spindleOn = s_r.spindleOn;

endmodule
